//--- hw/evs_pkg.sv
/*
  Package for the channel event selector: register offsets, field layout,
  reset codes, selector code map and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package evs_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int EVS_ADDR_W = 4;
  localparam logic [EVS_ADDR_W-1:0] EVS_OFS_SEL0 = 4'h0;
  localparam logic [EVS_ADDR_W-1:0] EVS_OFS_SEL1 = 4'h4;
  localparam logic [EVS_ADDR_W-1:0] EVS_OFS_SEL3 = 4'hc;
  localparam int EVS_NUM_REG = 3;
  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int EVS_CODE_W = 6;
  localparam int EVS_FIELD_PITCH = 8;
  localparam int EVS_FIELDS_PER_REG = 4;
  localparam int EVS_NUM_CH = 16;
  localparam int EVS_NUM_SRC = 16;
  localparam logic [31:0] EVS_WR_MASK = 32'h3f3f_3f3f;
  // ----------------------------------------------------------------------
  // Reset values: identity mapping
  // ----------------------------------------------------------------------
  localparam logic [31:0] EVS_RST_SEL0 = 32'h0302_0100;
  localparam logic [31:0] EVS_RST_SEL1 = 32'h0706_0504;
  localparam logic [31:0] EVS_RST_SEL3 = 32'h0f0e_0d0c;
  // ----------------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------------
  localparam logic [5:0] EVS_CODE_TIMER0 = 6'h01;
  localparam logic [5:0] EVS_CODE_RSV8 = 6'h08;
  localparam logic [5:0] EVS_CODE_RSV9 = 6'h09;
  localparam logic [5:0] EVS_CODE_RSVB = 6'h0b;
  localparam logic [5:0] EVS_CODE_LIMIT = 6'h10;
  // ----------------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] EVS_RESP_OKAY = 2'h0;
  localparam logic [1:0] EVS_RESP_SLVERR = 2'h2;
endpackage : evs_pkg

//--- hw/evs_route.sv
/*
  One channel router: picks one event source by a six-bit selector code
  and registers the result.
  Assumes source events are already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module evs_route (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [evs_pkg::EVS_CODE_W-1:0] code,
  input wire logic [evs_pkg::EVS_NUM_SRC-1:0] src_event,
  output logic trig_ff
);
  import evs_pkg::*;
  logic valid_code;
  // Reserved codes route nothing.
  assign valid_code = (code < EVS_CODE_LIMIT) && (code != EVS_CODE_RSV8) &&
                      (code != EVS_CODE_RSV9) && (code != EVS_CODE_RSVB);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= valid_code & src_event[code[3:0]];
    end
  end
endmodule : evs_route

//--- hw/evs_selector.sv
/*
  Channel event selector: three selector registers on AXI4-Lite steer one
  of the event sources onto each selectable trigger channel.
  Assumes source events are pulses on sys_clk; chained channels 8-11 are
  driven elsewhere, so their trigger outputs stay low.
*/
// Notes on behaviour
// - Bits 31:30, 23:22, 15:14, 7:6 read zero; writes to them ignored.
// - Each register holds four writable six-bit codes at 29:24, 21:16, 13:8, 5:0.
// - Field number n steers channel n, for n from 0 to 7 and 12 to 15.
// - Any source except 8, 9 and 11 may be routed to any selectable channel by its code.
// - Timer 0 code in field 15 makes timer 0 events trigger channel 15.
// - Codes 0-7, 10, 12-15 name sources; 8, 9, 11 and 16-63 are reserved.
// - After reset each field holds its own channel number.
// - Only three registers exist; channels 8-11 get no selected event.
`timescale 1ns/1ps
module evs_selector (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [evs_pkg::EVS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [evs_pkg::EVS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [evs_pkg::EVS_NUM_SRC-1:0] src_event,
  output logic [evs_pkg::EVS_NUM_CH-1:0] chan_trig
);
  import evs_pkg::*;
  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic [31:0] sel_ff [EVS_NUM_REG];
  logic aw_held_ff;
  logic w_held_ff;
  logic [EVS_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;
  logic [31:0] byte_mask;
  logic wr_hit;
  logic [1:0] wr_idx;
  logic awready_ff;
  logic wready_ff;
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  // Readies are registered from the next held state, so the bus sees flop
  // outputs with the same timing as a decode of the held flags would give.
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_bvalid = bvalid_ff;
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        nxt_aw_held = 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        nxt_w_held = 1'b1;
      end
      if (s_axi_bready) begin
        nxt_bvalid = 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end else begin
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff <= !nxt_w_held && !nxt_bvalid;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  always_comb begin
    wr_hit = 1'b1;
    wr_idx = 2'd0;
    case (awaddr_ff)
      EVS_OFS_SEL0: wr_idx = 2'd0;
      EVS_OFS_SEL1: wr_idx = 2'd1;
      EVS_OFS_SEL3: wr_idx = 2'd2;
      default: wr_hit = 1'b0;
    endcase
  end
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byte_mask[b*8 +: 8] = {8{wstrb_ff[b]}};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= EVS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? EVS_RESP_OKAY : EVS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // Selector registers
  // ----------------------------------------------------------------------
  // Only code bits take write data, so reserved pairs can never hold a one.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sel_ff[0] <= EVS_RST_SEL0;
      sel_ff[1] <= EVS_RST_SEL1;
      sel_ff[2] <= EVS_RST_SEL3;
    end else if (do_write && wr_hit) begin
      sel_ff[wr_idx] <= (sel_ff[wr_idx] & ~(byte_mask & EVS_WR_MASK)) |
                        (wdata_ff & byte_mask & EVS_WR_MASK);
    end
  end
  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic arready_ff;
  logic nxt_rvalid;
  assign s_axi_arready = arready_ff;
  always_comb begin
    nxt_rvalid = rvalid_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
    end else if (s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      arready_ff <= 1'b1;
    end else begin
      arready_ff <= !nxt_rvalid;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= EVS_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= EVS_RESP_OKAY;
      case (s_axi_araddr)
        EVS_OFS_SEL0: rdata_ff <= sel_ff[0] & EVS_WR_MASK;
        EVS_OFS_SEL1: rdata_ff <= sel_ff[1] & EVS_WR_MASK;
        EVS_OFS_SEL3: rdata_ff <= sel_ff[2] & EVS_WR_MASK;
        default: begin
          rdata_ff <= '0;
          rresp_ff <= EVS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // Channel routing
  // ----------------------------------------------------------------------
  logic [EVS_CODE_W-1:0] ch_code [EVS_NUM_CH];
  always_comb begin
    for (int c = 0; c < EVS_NUM_CH; c++) begin
      ch_code[c] = '0;
    end
    for (int r = 0; r < EVS_FIELDS_PER_REG; r++) begin
      ch_code[r] = sel_ff[0][r*EVS_FIELD_PITCH +: EVS_CODE_W];
      ch_code[r+4] = sel_ff[1][r*EVS_FIELD_PITCH +: EVS_CODE_W];
      ch_code[r+12] = sel_ff[2][r*EVS_FIELD_PITCH +: EVS_CODE_W];
    end
  end
  for (genvar c = 0; c < EVS_NUM_CH; c++) begin : g_ch
    if (c >= 8 && c <= 11) begin : g_chain
      // Chained channels have no selector; they stay quiet here.
      always_ff @(posedge sys_clk) begin
        chan_trig[c] <= 1'b0;
      end
    end else begin : g_sel
      evs_route u_route (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .code(ch_code[c]),
        .src_event(src_event),
        .trig_ff(chan_trig[c])
      );
    end
  end
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_rsv_read_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_axi_rvalid |-> (s_axi_rdata & ~EVS_WR_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  chk_field_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    (do_write && wr_hit && wr_idx == 2'd0 && wstrb_ff[0]) |=>
    sel_ff[0][5:0] == $past(wdata_ff[5:0]))
    else $error("code field not written");
  chk_field_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !do_write |=> $stable(sel_ff[2]))
    else $error("register changed without write");
  chk_timer_ch15: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ch_code[15] == EVS_CODE_TIMER0 && src_event[1]) |=> chan_trig[15])
    else $error("timer 0 did not trigger channel 15");
  chk_route_any: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ch_code[0] < EVS_CODE_LIMIT && ch_code[0] != EVS_CODE_RSV8 &&
     ch_code[0] != EVS_CODE_RSV9 && ch_code[0] != EVS_CODE_RSVB) |=>
    chan_trig[0] == $past(src_event[ch_code[0][3:0]]))
    else $error("channel 0 routing wrong");
  chk_map_ch13: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sel_ff[2][13:8] == EVS_RST_SEL3[13:8] && src_event[EVS_RST_SEL3[11:8]]) |=>
    chan_trig[13])
    else $error("field 13 not on channel 13");
  chk_chain_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    ##1 chan_trig[11:8] == 4'h0)
    else $error("chained channel triggered");
  chk_rsv_code_mute: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ch_code[7] >= EVS_CODE_LIMIT) |=> !chan_trig[7])
    else $error("reserved code routed an event");
  chk_reset_ident: assert property (@(posedge sys_clk)
    !nrst |=> sel_ff[1] == EVS_RST_SEL1 && sel_ff[0] == EVS_RST_SEL0)
    else $error("reset mapping not identity");
  chk_code_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ch_code[5] == EVS_CODE_RSVB) |=> !chan_trig[5])
    else $error("reserved code decoded");
endmodule : evs_selector

//--- tb/evs_src_model.sv
/*
  Event source model: drives one-cycle source pulses when asked.
  Assumes requests are set by non-blocking assignment after a rising edge.
*/
`timescale 1ns/1ps
module evs_src_model (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [evs_pkg::EVS_NUM_SRC-1:0] fire_mask,
  output logic [evs_pkg::EVS_NUM_SRC-1:0] src_event
);
  import evs_pkg::*;
  // Pulses last one cycle; lines rest low, so no stale level leaks on.
  always_ff @(posedge sys_clk) begin
    src_event <= fire ? fire_mask : '0;
  end
endmodule : evs_src_model

//--- tb/test_dma_event_channel_selector.sv
/*
  Self-checking bench for the channel event selector.
  Assumes the register bus answers within a few cycles and sources pulse on sys_clk.
*/
`timescale 1ns/1ps
module test_dma_event_channel_selector;
  import evs_pkg::*;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} evs_row_t;
  logic sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, fire;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rdat, mir [3];
  logic [1:0] bresp, rresp, resp;
  logic [15:0] src_event, chan_trig, fire_mask;
  evs_row_t rows [5];
  int error_cnt, samples_checked, k;
  evs_selector dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_event(src_event), .chan_trig(chan_trig));
  evs_src_model src_u (.sys_clk(sys_clk), .fire(fire), .fire_mask(fire_mask),
    .src_event(src_event));
  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp; bready <= 1'b0; break;
      end
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
    end
  endtask : rd
  function automatic int idx(input logic [3:0] a);
    return a == EVS_OFS_SEL0 ? 0 : a == EVS_OFS_SEL1 ? 1 : a == EVS_OFS_SEL3 ? 2 : -1;
  endfunction : idx
  // Reserved codes and channels 8-11 must never produce a trigger.
  function automatic logic [15:0] exp_trig(input int s);
    logic [15:0] t;
    logic [5:0] c;
    t = 16'h0000;
    for (int r = 0; r < 3; r++) for (int f = 0; f < 4; f++) begin
      c = mir[r][8*f +: 6];
      if (c < EVS_CODE_LIMIT && c != EVS_CODE_RSV8 && c != EVS_CODE_RSV9 &&
          c != EVS_CODE_RSVB && c == s) t[(r == 2 ? 12 : 4*r) + f] = 1'b1;
    end
    return t;
  endfunction : exp_trig
  task automatic route_all();
    for (int s = 0; s < 16; s++) begin
      @(posedge sys_clk);
      fire <= 1'b1; fire_mask <= 16'h0001 << s;
      @(posedge sys_clk);
      fire <= 1'b0;
      @(posedge sys_clk);
      #1 chk(chan_trig, exp_trig(s));
    end
  endtask : route_all
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; fire = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0000_0000;
    fire_mask = 16'h0000; error_cnt = 0; samples_checked = 0; wstrb = 4'hf;
    rows = '{'{4'hc, 32'h010e_0d0c, 32'h010e_0d0c, EVS_RESP_OKAY},
      '{4'h0, 32'h0a0f_083f, 32'h0a0f_083f, EVS_RESP_OKAY},
      '{4'h4, 32'hffc9_4bc1, 32'h3f09_0b01, EVS_RESP_OKAY},
      '{4'h8, 32'h0101_0101, 32'h0000_0000, EVS_RESP_SLVERR},
      '{4'h0, 32'h0000_0000, 32'h0000_0000, EVS_RESP_OKAY}};
    mir = '{EVS_RST_SEL0, EVS_RST_SEL1, EVS_RST_SEL3};
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      k = idx(rows[i].a);
      wr(rows[i].a, rows[i].d, resp);
      chk(resp, rows[i].r);
      if (k >= 0) mir[k] = rows[i].e;
      rd(rows[i].a, rdat, resp);
      chk(rdat, rows[i].e);
      chk(resp, rows[i].r);
      route_all();
    end
    $display("table rows done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    mir = '{EVS_RST_SEL0, EVS_RST_SEL1, EVS_RST_SEL3};
    rd(EVS_OFS_SEL0, rdat, resp);
    chk(rdat, EVS_RST_SEL0);
    rd(EVS_OFS_SEL1, rdat, resp);
    chk(rdat, EVS_RST_SEL1);
    rd(EVS_OFS_SEL3, rdat, resp);
    chk(rdat, EVS_RST_SEL3);
    route_all();
    $display("reset test done");
    // Only byte lane 0 is enabled, so the other three fields must keep their codes.
    wstrb <= 4'h1;
    wr(EVS_OFS_SEL1, 32'h0b0b_0b0a, resp);
    chk(resp, EVS_RESP_OKAY);
    wstrb <= 4'hf;
    mir[1] = 32'h0706_050a;
    rd(EVS_OFS_SEL1, rdat, resp);
    chk(rdat, mir[1]);
    route_all();
    $display("byte lane test done");
    test_done();
  end
endmodule : test_dma_event_channel_selector
